// >>> hw/cpmh_pkg.sv
// package of constants, encodings and carriers for the cluster power mode handshake
package cpmh_pkg;

  // mode encoding on the requested-state bus and the requirement bus
  localparam int MODE_W = 5;
  localparam logic [4:0] MODE_OFF        = 5'h00;
  localparam logic [4:0] MODE_SF_ON      = 5'h08;
  localparam logic [4:0] MODE_Q_ON       = 5'h09;
  localparam logic [4:0] MODE_H_ON       = 5'h0a;
  localparam logic [4:0] MODE_TQ_ON      = 5'h0b;
  localparam logic [4:0] MODE_FULL_ON    = 5'h0c;
  localparam logic [4:0] MODE_SF_FRET    = 5'h10;
  localparam logic [4:0] MODE_Q_FRET     = 5'h11;
  localparam logic [4:0] MODE_H_FRET     = 5'h12;
  localparam logic [4:0] MODE_TQ_FRET    = 5'h13;
  localparam logic [4:0] MODE_FULL_FRET  = 5'h14;
  localparam logic [4:0] MODE_Q_MRET     = 5'h01;
  localparam logic [4:0] MODE_H_MRET     = 5'h02;
  localparam logic [4:0] MODE_TQ_MRET    = 5'h03;
  localparam logic [4:0] MODE_FULL_MRET  = 5'h04;

  // mode field layout: class in bits 4:3, capacity in bits 2:0
  localparam int CLS_HI = 4;
  localparam int CLS_LO = 3;
  localparam int CAP_HI = 2;
  localparam int CAP_LO = 0;
  localparam logic [1:0] CLS_OFF  = 2'h0;
  localparam logic [1:0] CLS_ON   = 2'h1;
  localparam logic [1:0] CLS_FRET = 2'h2;

  // capacity codes
  localparam logic [2:0] CAP_NONE = 3'h0;
  localparam logic [2:0] CAP_Q    = 3'h1;
  localparam logic [2:0] CAP_H    = 3'h2;
  localparam logic [2:0] CAP_TQ   = 3'h3;
  localparam logic [2:0] CAP_FULL = 3'h4;

  // l3 portion geometry
  localparam int WAYS_PER_GROUP = 4;
  localparam int TAG_PORTIONS   = 4;
  localparam int DATA_PORTIONS  = 2;
  localparam int GROUPS_PER_DATA = 2;

  // preparation time for each accepted transition, in clock cycles
  localparam logic [7:0] PREP_CYCLES = 8'h08;
  localparam logic [7:0] CNT_ZERO    = 8'h00;
  localparam logic [7:0] CNT_ONE     = 8'h01;

  // idle duration and counter widths
  localparam int IDLE_W = 16;
  localparam int HIT_W  = 32;

  // power status carrier
  typedef struct packed {
    logic [4:0] mode;
    logic [3:0] tag_on;
    logic [1:0] data_on;
    logic       ram_retained;
    logic       logic_off;
    logic       sf_long_term_buffer_on;
  } cpmh_status_type;

  // handshake request carrier
  typedef struct packed {
    logic       req;
    logic [4:0] state;
  } cpmh_preq_type;

endpackage : cpmh_pkg

// >>> hw/cpmh_top.sv
// cluster-side power mode handshake and l3 power control logic
`timescale 1ns/1ps
module cpmh_top #(
  parameter int IDLE_W = cpmh_pkg::IDLE_W,
  parameter int HIT_W  = cpmh_pkg::HIT_W
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // p-channel from the power controller
  input  wire logic                      mode_request,
  input  wire logic [4:0]                requested_state_bus,
  output logic                           mode_accept,
  output logic                           mode_deny,
  output logic [4:0]                     cluster_requirement_bus,
  // software control bits
  input  wire logic [2:0]                target_capacity,
  input  wire logic                      functional_retention_mode_enable,
  input  wire logic [IDLE_W-1:0]         functional_retention_mode_idle_cycles,
  input  wire logic                      memory_retention_mode_required,
  input  wire logic                      debug_recovery,
  // cluster activity
  input  wire logic                      all_cores_off,
  input  wire logic                      l3_access,
  input  wire logic                      l3_hit,
  input  wire logic                      l3_pending,
  output logic                           l3_stall,
  output logic                           l3_invalidate,
  // status
  output cpmh_pkg::cpmh_status_type      power_status_reg,
  output logic [HIT_W-1:0]               l3_hit_counter,
  output logic [HIT_W-1:0]               l3_miss_counter
);

  // handshake states, one-hot
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_PREP = 4'b0010,
    HS_ACK  = 4'b0100,
    HS_NAK  = 4'b1000
  } cpmh_hs_type;

  // two-flop synchronisers on pin inputs
  cpmh_pkg::cpmh_preq_type preq_s1, preq_s2;          // p-channel request
  logic [5:0]  act_s1, act_s2;                        // activity pins
  logic [2:0]  cap_s1, cap_s2;                        // capacity selection
  logic [2:0]  ctl_s1, ctl_s2;                        // control bits
  logic [IDLE_W-1:0] idle_s1, idle_s2;                // idle duration setting
  logic [1:0]  sync_fill;                             // synchronisers filled after reset

  cpmh_hs_type       hs, next_hs;                     // handshake state
  logic [4:0]        mode;                            // current accepted mode
  logic [4:0]        target;                          // latched requested mode
  logic [7:0]        prep_cnt;                        // preparation counter
  logic [IDLE_W-1:0] idle_cnt;                        // inactivity counter
  logic              init_done;                       // reset mode sampled
  logic              inval;                           // invalidate pulse flop

  // synchronised aliases
  wire       req_i      = preq_s2.req;
  wire [4:0] state_i    = preq_s2.state;
  wire       cores_off  = act_s2[0];
  wire       access_i   = act_s2[1];
  wire       hit_i      = act_s2[2];
  wire       pending_i  = act_s2[3];
  wire       fret_en    = ctl_s2[0];
  wire       mret_req   = ctl_s2[1];
  wire       dbg_rec    = ctl_s2[2];

  // mode field decode, used for several modes
  function automatic logic [1:0] cls_of(input logic [4:0] m);
    cls_of = m[cpmh_pkg::CLS_HI:cpmh_pkg::CLS_LO];
  endfunction : cls_of

  function automatic logic [2:0] cap_of(input logic [4:0] m);
    cap_of = m[cpmh_pkg::CAP_HI:cpmh_pkg::CAP_LO];
  endfunction : cap_of

  // mode is well formed
  function automatic logic legal(input logic [4:0] m);
    legal = (m == cpmh_pkg::MODE_OFF) ||
            ((cls_of(m) != cpmh_pkg::CLS_OFF) && (cap_of(m) <= cpmh_pkg::CAP_FULL)) ||
            ((cls_of(m) == cpmh_pkg::CLS_OFF) && (cap_of(m) >= cpmh_pkg::CAP_Q) &&
             (cap_of(m) <= cpmh_pkg::CAP_FULL));
  endfunction : legal

  // capacity to tag portion enables
  function automatic logic [3:0] tag_en(input logic [2:0] c);
    case (c)
      cpmh_pkg::CAP_Q:    tag_en = 4'h1;
      cpmh_pkg::CAP_H:    tag_en = 4'h3;
      cpmh_pkg::CAP_TQ:   tag_en = 4'h7;
      cpmh_pkg::CAP_FULL: tag_en = 4'hf;
      default:            tag_en = 4'h0;
    endcase
  endfunction : tag_en

  // capacity to data portion enables
  function automatic logic [1:0] data_en(input logic [2:0] c);
    case (c)
      cpmh_pkg::CAP_Q, cpmh_pkg::CAP_H:  data_en = 2'h1;
      cpmh_pkg::CAP_TQ, cpmh_pkg::CAP_FULL: data_en = 2'h3;
      default:                           data_en = 2'h0;
    endcase
  endfunction : data_en

  // transition validity
  wire [1:0] cur_cls = cls_of(mode);
  wire [2:0] cur_cap = cap_of(mode);
  wire [1:0] req_cls = cls_of(state_i);
  wire [2:0] req_cap = cap_of(state_i);
  wire       cur_off = (mode == cpmh_pkg::MODE_OFF);
  wire       cur_mret = (cur_cls == cpmh_pkg::CLS_OFF) && !cur_off;
  wire       step_ok = (req_cap == cur_cap + 3'h1) || (cur_cap == req_cap + 3'h1);
  wire       idle_now = !access_i && !pending_i;
  wire       to_on_ok = (req_cls == cpmh_pkg::CLS_ON) &&
                        ((cur_cls == cpmh_pkg::CLS_ON && step_ok) ||
                         (cur_cls == cpmh_pkg::CLS_FRET && req_cap == cur_cap) ||
                         cur_off || (cur_mret && req_cap == cur_cap));
  wire       to_fret_ok = (req_cls == cpmh_pkg::CLS_FRET) &&
                          (cur_cls == cpmh_pkg::CLS_ON) && (req_cap == cur_cap) && fret_en;
  wire       to_mret_ok = (req_cls == cpmh_pkg::CLS_OFF) && (state_i != cpmh_pkg::MODE_OFF) &&
                          cores_off && idle_now && (cur_cls == cpmh_pkg::CLS_ON) &&
                          (req_cap == cur_cap);
  wire       to_off_ok = (state_i == cpmh_pkg::MODE_OFF) && cores_off;
  // stale: capacity request no longer matches software target
  wire       stale = (req_cls == cpmh_pkg::CLS_ON) && (cur_cls == cpmh_pkg::CLS_ON) &&
                     (req_cap != cap_s2);
  wire       valid_req = legal(state_i) && (state_i != mode) && !stale &&
                         (to_on_ok || to_fret_ok || to_mret_ok || to_off_ok);

  // requirement advertisement
  wire idle_done = fret_en && (idle_cnt >= idle_s2);
  wire [2:0] step_cap = (cap_s2 > cur_cap) ? cur_cap + 3'h1 :
                        (cap_s2 < cur_cap) ? cur_cap - 3'h1 : cur_cap;
  logic [4:0] next_req;

  // choose the mode to advertise
  always_comb begin
    next_req = mode;
    if (cur_off || cur_mret) begin
      next_req = {cpmh_pkg::CLS_ON, cur_off ? cpmh_pkg::CAP_NONE : cur_cap};
    end else if (cur_cls == cpmh_pkg::CLS_FRET) begin
      next_req = access_i ? {cpmh_pkg::CLS_ON, cur_cap} : mode;
    end else if (cores_off && mret_req && idle_now && cur_cap != cpmh_pkg::CAP_NONE) begin
      next_req = {cpmh_pkg::CLS_OFF, cur_cap};
    end else if (idle_done) begin
      next_req = {cpmh_pkg::CLS_FRET, cur_cap};
    end else begin
      next_req = {cpmh_pkg::CLS_ON, step_cap};
    end
  end

  // handshake next state
  always_comb begin
    next_hs = hs;
    case (hs)
      HS_IDLE: if (req_i && init_done) next_hs = valid_req ? HS_PREP : HS_NAK;
      HS_PREP: if (prep_cnt == cpmh_pkg::CNT_ONE) next_hs = HS_ACK;
      HS_ACK:  if (!req_i) next_hs = HS_IDLE;
      HS_NAK:  if (!req_i) next_hs = HS_IDLE;
      default: next_hs = HS_IDLE;
    endcase
  end

  // input synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preq_s1 <= '0;
      preq_s2 <= '0;
      act_s1  <= '0;
      act_s2  <= '0;
      cap_s1  <= cpmh_pkg::CAP_NONE;
      cap_s2  <= cpmh_pkg::CAP_NONE;
      ctl_s1  <= '0;
      ctl_s2  <= '0;
      idle_s1 <= '0;
      idle_s2 <= '0;
      sync_fill <= '0;
    end else begin
      preq_s1 <= '{req: mode_request, state: requested_state_bus};
      preq_s2 <= preq_s1;
      act_s1  <= {2'b00, l3_pending, l3_hit, l3_access, all_cores_off};
      act_s2  <= act_s1;
      cap_s1  <= target_capacity;
      cap_s2  <= cap_s1;
      ctl_s1  <= {debug_recovery, memory_retention_mode_required, functional_retention_mode_enable};
      ctl_s2  <= ctl_s1;
      idle_s1 <= functional_retention_mode_idle_cycles;
      idle_s2 <= idle_s1;
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  // initial mode capture after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done <= 1'b0;
      mode      <= cpmh_pkg::MODE_OFF;
      inval     <= 1'b0;
    end else begin
      inval <= 1'b0;
      if (!init_done) begin
        // wait until the synchronisers hold the pin value seen through reset
        init_done <= sync_fill[1];
        mode      <= (sync_fill[1] && legal(state_i)) ? state_i : cpmh_pkg::MODE_OFF;
        inval     <= sync_fill[1] && (cls_of(state_i) == cpmh_pkg::CLS_ON) && !dbg_rec;
      end else if (hs == HS_PREP && next_hs == HS_ACK) begin
        mode  <= target;
        inval <= cur_off && (cls_of(target) == cpmh_pkg::CLS_ON) && !dbg_rec;
      end
    end
  end

  // handshake state, target latch, preparation counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs       <= HS_IDLE;
      target   <= cpmh_pkg::MODE_OFF;
      prep_cnt <= cpmh_pkg::CNT_ZERO;
    end else begin
      hs <= next_hs;
      if (hs == HS_IDLE && next_hs == HS_PREP) begin
        target   <= state_i;
        prep_cnt <= cpmh_pkg::PREP_CYCLES;
      end else if (prep_cnt != cpmh_pkg::CNT_ZERO) begin
        prep_cnt <= prep_cnt - cpmh_pkg::CNT_ONE;
      end
    end
  end

  // inactivity counter for functional retention
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= '0;
    end else if (!idle_now || cur_cls != cpmh_pkg::CLS_ON) begin
      idle_cnt <= '0;
    end else if (idle_cnt < idle_s2) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_accept             <= 1'b0;
      mode_deny               <= 1'b0;
      cluster_requirement_bus <= cpmh_pkg::MODE_OFF;
    end else begin
      mode_accept             <= (next_hs == HS_ACK);
      mode_deny               <= (next_hs == HS_NAK);
      cluster_requirement_bus <= next_req;
    end
  end

  // l3 hit and miss counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l3_hit_counter  <= '0;
      l3_miss_counter <= '0;
    end else if (access_i) begin
      if (hit_i) l3_hit_counter <= l3_hit_counter + 1'b1;
      else l3_miss_counter <= l3_miss_counter + 1'b1;
    end
  end

  // stall traffic only while rams are in retention or logic off
  assign l3_stall      = (cur_cls != cpmh_pkg::CLS_ON);
  assign l3_invalidate = inval;

  // power status: portion enables and retention state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_status_reg <= '0;
    end else begin
      power_status_reg.mode         <= mode;
      power_status_reg.tag_on       <= cur_cls == cpmh_pkg::CLS_ON ? tag_en(cur_cap) : 4'h0;
      power_status_reg.data_on      <= cur_cls == cpmh_pkg::CLS_ON ? data_en(cur_cap) : 2'h0;
      power_status_reg.ram_retained <= cur_mret || cur_cls == cpmh_pkg::CLS_FRET;
      power_status_reg.logic_off    <= cur_mret || cur_off;
      power_status_reg.sf_long_term_buffer_on   <= cur_cls != cpmh_pkg::CLS_OFF;
    end
  end

endmodule : cpmh_top

// >>> tb/cpmh_monitor.sv
// checker on the power mode handshake ports
`timescale 1ns/1ps
module cpmh_monitor (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst_n,
  // handshake
  input wire logic                      mode_request,
  input wire logic                      mode_accept,
  input wire logic                      mode_deny,
  // cluster side
  input wire logic                      all_cores_off,
  input wire logic                      debug_recovery,
  input wire logic                      l3_stall,
  input wire logic                      l3_invalidate,
  input wire cpmh_pkg::cpmh_status_type power_status_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic [2:0] cap = power_status_reg.mode[2:0]; // reported capacity
  wire logic [1:0] cls = power_status_reg.mode[4:3]; // reported class
  // portion enables expected for the reported capacity
  wire logic [3:0] exp_tag = (cap == cpmh_pkg::CAP_FULL) ? 4'hf : (cap == cpmh_pkg::CAP_TQ) ?
    4'h7 : (cap == cpmh_pkg::CAP_H) ? 4'h3 : (cap == cpmh_pkg::CAP_Q) ? 4'h1 : 4'h0;
  wire logic [1:0] exp_data = (cap >= cpmh_pkg::CAP_TQ) ? 2'h3 :
    (cap != cpmh_pkg::CAP_NONE) ? 2'h1 : 2'h0;
  // memory retention reported
  wire logic mret = (cls == cpmh_pkg::CLS_OFF) && (cap != cpmh_pkg::CAP_NONE);
  // either answer present
  sequence s_answer;
    mode_accept || mode_deny;
  endsequence
  // controller drops its request while accepted
  sequence s_release;
    $fell(mode_request) ##0 mode_accept;
  endsequence
  chk_answer_excl: assert property (!(mode_accept && mode_deny))
    else $error("accept and deny high together");
  chk_answer_cause: assert property ($rose(mode_accept || mode_deny) |-> $past(mode_request))
    else $error("answer without request");
  chk_prep_time: assert property ($rose(mode_accept) |-> $past(mode_request, 8))
    else $error("accept before preparation time");
  chk_answer_bound: assert property ($rose(mode_request) |-> ##[1:16] s_answer)
    else $error("request not answered in time");
  chk_accept_hold: assert property (mode_accept && mode_request |=> mode_accept)
    else $error("accept dropped while request high");
  chk_accept_drop: assert property (s_release |-> ##[1:6] !mode_accept)
    else $error("accept not released");
  chk_stall_mode: assert property (!l3_stall |=> cls == cpmh_pkg::CLS_ON)
    else $error("traffic not stalled outside on modes");
  chk_portion_map: assert property (cls == cpmh_pkg::CLS_ON |->
    power_status_reg.tag_on == exp_tag && power_status_reg.data_on == exp_data)
    else $error("portion enables wrong for capacity");
  chk_inval_pulse: assert property (l3_invalidate |-> !debug_recovery ##1 !l3_invalidate)
    else $error("invalidate not a single pulse");
  chk_logic_off_entry: assert property ($rose(mret) |-> $past(all_cores_off, 3))
    else $error("memory retention entered with cores on");
  chk_mret_status: assert property (cls == cpmh_pkg::CLS_OFF && cap != cpmh_pkg::CAP_NONE |->
    power_status_reg.ram_retained && power_status_reg.logic_off &&
    !power_status_reg.sf_long_term_buffer_on)
    else $error("memory retention status wrong");
endmodule : cpmh_monitor

bind cpmh_top cpmh_monitor cpmh_monitor_i (.clk(clk), .rst_n(rst_n),
  .mode_request(mode_request), .mode_accept(mode_accept), .mode_deny(mode_deny),
  .all_cores_off(all_cores_off), .debug_recovery(debug_recovery), .l3_stall(l3_stall),
  .l3_invalidate(l3_invalidate), .power_status_reg(power_status_reg));

// >>> tb/cpmh_pctl_model.sv
// behavioural power controller on the far side of the handshake
`timescale 1ns/1ps
module cpmh_pctl_model (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // handshake
  output logic       mode_request,
  output logic [4:0] requested_state_bus,
  input  wire logic  mode_accept,
  input  wire logic  mode_deny
);
  logic ready; // post-reset wait over
  // initial mode held through reset, request low, then the long wait
  initial begin
    mode_request        = 1'b0;
    requested_state_bus = cpmh_pkg::MODE_FULL_ON;
    ready               = 1'b0;
    @(posedge rst_n);
    repeat (72) @(posedge clk);
    ready = 1'b1;
  end
  // one four-phase transfer, reporting the answer seen
  task automatic xfer(input logic [4:0] st, output logic acc, output logic den);
    int n;
    while (!ready) @(posedge clk);
    @(posedge clk);
    mode_request        <= 1'b1;
    requested_state_bus <= st;
    for (n = 0; n < 40 && mode_accept !== 1'b1 && mode_deny !== 1'b1; n++) @(posedge clk);
    acc = mode_accept;
    den = mode_deny;
    // released lines show garbage, not the old value
    mode_request        <= 1'b0;
    requested_state_bus <= ~st;
    @(posedge clk);
    for (n = 0; n < 10 && (mode_accept !== 1'b0 || mode_deny !== 1'b0); n++) @(posedge clk);
  endtask : xfer
endmodule : cpmh_pctl_model

// >>> tb/cpmh_top_bench.sv
// self-checking testbench of the power mode handshake
`timescale 1ns/1ps
module cpmh_top_bench;
  logic clk, rst_n, mode_request, mode_accept, mode_deny; // clock, reset, handshake
  logic [4:0] requested_state_bus, cluster_requirement_bus; // mode buses
  logic [2:0] target_capacity; // software capacity target
  logic functional_retention_mode_enable, memory_retention_mode_required, debug_recovery; // software bits
  logic [15:0] functional_retention_mode_idle_cycles; // idle time before retention
  logic all_cores_off, l3_access, l3_hit, l3_pending, l3_stall, l3_invalidate; // activity
  cpmh_pkg::cpmh_status_type power_status_reg; // status
  logic [31:0] l3_hit_counter, l3_miss_counter; // counters
  int err_count = 0; // mismatches
  int n_tests = 0; // comparisons
  int inv_n = 0; // invalidate pulses seen
  // capacity steps: target, state, accepted, tag enables, data enables
  logic [14:0] steps [7] = '{
    {3'h4, cpmh_pkg::MODE_H_ON, 1'b0, 4'hf, 2'h3}, {3'h2, cpmh_pkg::MODE_TQ_ON, 1'b0, 4'hf, 2'h3},
    {3'h3, cpmh_pkg::MODE_TQ_ON, 1'b1, 4'h7, 2'h3}, {3'h2, cpmh_pkg::MODE_H_ON, 1'b1, 4'h3, 2'h1},
    {3'h1, cpmh_pkg::MODE_Q_ON, 1'b1, 4'h1, 2'h1}, {3'h0, cpmh_pkg::MODE_SF_ON, 1'b1, 4'h0, 2'h0},
    {3'h1, cpmh_pkg::MODE_Q_ON, 1'b1, 4'h1, 2'h1}};

  cpmh_top #(.IDLE_W(16), .HIT_W(32)) cpmh_top_i (.clk(clk), .rst_n(rst_n),
    .mode_request(mode_request), .requested_state_bus(requested_state_bus),
    .mode_accept(mode_accept), .mode_deny(mode_deny),
    .cluster_requirement_bus(cluster_requirement_bus), .target_capacity(target_capacity),
    .functional_retention_mode_enable(functional_retention_mode_enable), .functional_retention_mode_idle_cycles(functional_retention_mode_idle_cycles),
    .memory_retention_mode_required(memory_retention_mode_required), .debug_recovery(debug_recovery),
    .all_cores_off(all_cores_off), .l3_access(l3_access), .l3_hit(l3_hit),
    .l3_pending(l3_pending), .l3_stall(l3_stall), .l3_invalidate(l3_invalidate),
    .power_status_reg(power_status_reg), .l3_hit_counter(l3_hit_counter),
    .l3_miss_counter(l3_miss_counter));
  cpmh_pctl_model cpmh_pctl_model_i (.clk(clk), .rst_n(rst_n), .mode_request(mode_request),
    .requested_state_bus(requested_state_bus), .mode_accept(mode_accept),
    .mode_deny(mode_deny));

  // clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // invalidate pulse counter
  always @(posedge clk) if (l3_invalidate === 1'b1) inv_n <= inv_n + 1;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one handshake with the expected answer
  task automatic req(input logic [4:0] st, input logic exp_acc);
    logic acc, den;
    cpmh_pctl_model_i.xfer(st, acc, den);
    check({30'h0, acc, den}, {30'h0, exp_acc, ~exp_acc});
  endtask : req
  // bounded wait for an advertised requirement
  task automatic wait_adv(input logic [4:0] v, input int lim);
    for (int n = 0; n < lim && cluster_requirement_bus !== v; n++) @(posedge clk);
    check({27'h0, cluster_requirement_bus}, {27'h0, v});
  endtask : wait_adv
  // closing report
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // watchdog
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    print_verdict;
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    target_capacity = cpmh_pkg::CAP_FULL;
    {functional_retention_mode_enable, memory_retention_mode_required, debug_recovery, all_cores_off} = 4'h0;
    {l3_access, l3_hit, l3_pending} = 3'h0;
    functional_retention_mode_idle_cycles = 16'h0010;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // three hits then two misses
    repeat (4) @(posedge clk);
    {l3_access, l3_hit} <= 2'h3;
    repeat (3) @(posedge clk);
    l3_hit <= 1'b0;
    repeat (2) @(posedge clk);
    l3_access <= 1'b0;
    repeat (6) @(posedge clk);
    check(l3_hit_counter, 32'h0000_0003);
    check(l3_miss_counter, 32'h0000_0002);
    check({27'h0, power_status_reg.mode}, {27'h0, cpmh_pkg::MODE_FULL_ON});
    check(inv_n, 32'h0000_0001);
    // capacity steps, stale and skipping requests denied
    foreach (steps[i]) begin
      target_capacity <= steps[i][14:12];
      repeat (4) @(posedge clk);
      req(steps[i][11:7], steps[i][6]);
      check({28'h0, power_status_reg.tag_on}, {28'h0, steps[i][5:2]});
      check({30'h0, power_status_reg.data_on}, {30'h0, steps[i][1:0]});
    end
    // functional retention entry, exit on access, re-entry advertised
    functional_retention_mode_enable <= 1'b1;
    wait_adv(cpmh_pkg::MODE_Q_FRET, 80);
    req(cpmh_pkg::MODE_Q_FRET, 1'b1);
    check({31'h0, l3_stall}, 32'h0000_0001);
    l3_access <= 1'b1;
    wait_adv(cpmh_pkg::MODE_Q_ON, 20);
    req(cpmh_pkg::MODE_Q_ON, 1'b1);
    check({31'h0, l3_stall}, 32'h0000_0000);
    l3_access <= 1'b0;
    wait_adv(cpmh_pkg::MODE_Q_FRET, 80);
    functional_retention_mode_enable <= 1'b0;
    repeat (4) @(posedge clk);
    // off needs all cores off
    req(cpmh_pkg::MODE_OFF, 1'b0);
    all_cores_off <= 1'b1;
    repeat (4) @(posedge clk);
    req(cpmh_pkg::MODE_OFF, 1'b1);
    req(cpmh_pkg::MODE_Q_ON, 1'b1);
    check(inv_n, 32'h0000_0002);
    // memory retention entry and its status
    memory_retention_mode_required <= 1'b1;
    wait_adv(cpmh_pkg::MODE_Q_MRET, 40);
    req(cpmh_pkg::MODE_Q_MRET, 1'b1);
    check({29'h0, power_status_reg.ram_retained, power_status_reg.logic_off,
      power_status_reg.sf_long_term_buffer_on}, 32'h0000_0006);
    check({31'h0, l3_stall}, 32'h0000_0001);
    // back on, then off while memory retention is advertised
    req(cpmh_pkg::MODE_Q_ON, 1'b1);
    wait_adv(cpmh_pkg::MODE_Q_MRET, 40);
    req(cpmh_pkg::MODE_OFF, 1'b1);
    // debug recovery keeps the l3 contents on the way back on
    debug_recovery <= 1'b1;
    repeat (4) @(posedge clk);
    req(cpmh_pkg::MODE_Q_ON, 1'b1);
    check(inv_n, 32'h0000_0002);
    print_verdict;
  end
endmodule : cpmh_top_bench
